// ===== hw/tsr_pkg.sv
package tsr_pkg;

  // ****************************************************************
  // register map and field layout
  // ****************************************************************
  localparam int           TSR_SEGMENTS   = 4;          // track segments on the board
  localparam int           TSR_DATA_W     = 8;          // register width
  localparam int           TSR_ADDR_W     = 20;         // bus address lines a0..a19
  localparam logic         TSR_OFF_CTRL   = 1'h0;       // power/direction register offset
  localparam logic         TSR_OFF_SENSE  = 1'h1;       // sense status register offset
  localparam int           TSR_DIR_POS    = 0;          // direction bit within a pair
  localparam int           TSR_PWR_POS    = 1;          // power bit within a pair
  localparam int           TSR_CUR_POS    = 0;          // current bit within a pair
  localparam int           TSR_VOLT_POS   = 1;          // voltage bit within a pair
  localparam int           TSR_IO_TOP     = 11;         // highest line compared in io space
  localparam logic [7:0]   TSR_CTRL_RST   = 8'h00;      // power/direction value after reset
  localparam logic [7:0]   TSR_SENSE_RST  = 8'h00;      // sense register value after reset

  // ****************************************************************
  // sensor pair decode
  // ****************************************************************
  typedef enum logic [1:0] {
    TSR_SEG_FAULT = 2'h0,                               // volt 0 current 0
    TSR_SEG_SHORT = 2'h1,                               // volt 0 current 1
    TSR_SEG_EMPTY = 2'h2,                               // volt 1 current 0
    TSR_SEG_TRAIN = 2'h3                                // volt 1 current 1
  } tsr_seg_state_t;

  // ****************************************************************
  // bus carriers
  // ****************************************************************
  typedef struct packed {
    logic [TSR_ADDR_W-1:0] addr;                        // address lines
    logic                  adr_strobe;                  // address strobe, active high here
    logic                  dat_strobe;                  // data strobe, active high here
    logic                  mem_space;                   // 1 memory, 0 io
    logic                  rd;                          // 1 read, 0 write
    logic [7:0]            wdata;                       // write data
  } tsr_bus_req_t;

  typedef struct packed {
    logic       transfer_acknowledge;                   // transfer done
    logic       transfer_error;                         // transfer refused
    logic       rdata_oe_n;                             // data drive enable, low drives
    logic [7:0] rdata;                                  // read data
  } tsr_bus_rsp_t;

endpackage : tsr_pkg

// ===== hw/tsr_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a single level
module tsr_sync (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic meta;                                         // first stage, read only by second
    logic sync;                                         // second stage
  } tsr_sync_state_t;

  tsr_sync_state_t s_q;                                 // registered state
  tsr_sync_state_t s_d;                                 // next state

  // next state: shift the level through
  always_comb begin
    s_d      = s_q;
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  // register, cleared to absent supply
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;

endmodule : tsr_sync

// ===== hw/tsr_regs.sv
`timescale 1ns/1ps
// two byte-wide registers with registered read data
module tsr_regs (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clr,
  input  wire logic       ctrl_we,
  input  wire logic [7:0] ctrl_wdata,
  input  wire logic       sense_cap,
  input  wire logic [7:0] sense_in,
  input  wire logic       rd_sel,
  output logic      [7:0] ctrl_out,
  output logic      [7:0] rdata
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl;                                   // power/direction
    logic [7:0] sense;                                  // sense status
    logic [7:0] rdata;                                  // read data register
  } tsr_regs_state_t;

  tsr_regs_state_t s_q;                                 // registered state
  tsr_regs_state_t s_d;                                 // next state

  // next state: writes, captures and read mux
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.ctrl = tsr_pkg::TSR_CTRL_RST;
    end else if (ctrl_we) begin
      s_d.ctrl = ctrl_wdata;
    end
    if (sense_cap) begin
      s_d.sense = sense_in;
    end
    // sense read returns the value being captured this cycle
    if (rd_sel == tsr_pkg::TSR_OFF_SENSE) begin
      s_d.rdata = sense_cap ? sense_in : s_q.sense;
    end else begin
      s_d.rdata = s_d.ctrl;
    end
  end

  // register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= {tsr_pkg::TSR_CTRL_RST, tsr_pkg::TSR_SENSE_RST, 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign ctrl_out = s_q.ctrl;
  assign rdata    = s_q.rdata;

endmodule : tsr_regs

// ===== hw/tsr_top.sv
`timescale 1ns/1ps
module tsr_top #(
  parameter int SEGMENTS = tsr_pkg::TSR_SEGMENTS
) (
  input  wire logic                              sys_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              sys_reset_n,
  input  wire logic                              supply_good,
  input  wire logic [tsr_pkg::TSR_ADDR_W-1:1]    address_match_jumpers,
  input  wire logic                              memory_space_enable_jumper,
  input  wire logic                              io_space_enable_jumper,
  input  wire tsr_pkg::tsr_bus_req_t             bus_req,
  input  wire logic [SEGMENTS-1:0]               seg_voltage_ok,
  input  wire logic [SEGMENTS-1:0]               seg_current_flow,
  output tsr_pkg::tsr_bus_rsp_t                  bus_rsp,
  output logic      [SEGMENTS-1:0]               seg_power_on,
  output logic      [SEGMENTS-1:0]               seg_polarity,
  output logic      [SEGMENTS-1:0]               seg_state_bad,
  output logic                                   fail_ind,
  output logic                                   activity_ind
);

  // ****************************************************************
  // transfer sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    TSR_IDLE  = 4'h1,                                   // waiting for strobes
    TSR_RDLY  = 4'h2,                                   // read acknowledge delay
    TSR_HOLD  = 4'h4,                                   // answer held until strobes drop
    TSR_QUIET = 4'h8                                    // ignored transfer, wait strobes
  } tsr_fsm_t;

  // ****************************************************************
  // block state
  // ****************************************************************
  typedef struct packed {
    tsr_fsm_t                       fsm;                // sequencer
    logic                           ack;                // acknowledge output
    logic                           err;                // transfer error output
    logic                           oe_n;               // data drive enable
    logic                           fail;               // fail indicator
    logic                           act;                // activity pulse
    logic [SEGMENTS-1:0]            pwr;                // power outputs
    logic [SEGMENTS-1:0]            pol;                // polarity outputs
    logic [SEGMENTS-1:0]            bad;                // short or fault per segment
  } tsr_state_t;

  tsr_state_t s_q;                                      // registered state
  tsr_state_t s_d;                                      // next state

  // ****************************************************************
  // helpers
  // ****************************************************************
  // pair layout: bit 2n+pos of the register
  function automatic logic pair_bit(input logic [7:0] r, input int seg, input int pos);
    pair_bit = r[2*seg+pos];
  endfunction : pair_bit

  // address compare; io space stops at line a11
  function automatic logic addr_hit(input logic [tsr_pkg::TSR_ADDR_W-1:1] a,
                                    input logic [tsr_pkg::TSR_ADDR_W-1:1] j,
                                    input logic                           mem);
    logic lo_ok;
    logic hi_ok;
    lo_ok = (a[tsr_pkg::TSR_IO_TOP:1] == j[tsr_pkg::TSR_IO_TOP:1]);
    hi_ok = (a[tsr_pkg::TSR_ADDR_W-1:tsr_pkg::TSR_IO_TOP+1]
             == j[tsr_pkg::TSR_ADDR_W-1:tsr_pkg::TSR_IO_TOP+1]);
    addr_hit = mem ? (lo_ok && hi_ok) : lo_ok;
  endfunction : addr_hit

  // ****************************************************************
  // supply synchroniser and control clear
  // ****************************************************************
  logic supply_ok;                                      // synchronised supply-good

  tsr_sync u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .din     (supply_good),
    .dout    (supply_ok)
  );

  logic clr;                                            // clear condition
  assign clr = !sys_reset_n || !supply_ok;

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic strobes;                                        // both strobes active
  logic hit;                                            // board address matched
  logic space_en;                                       // requested space enabled
  logic reg_sel;                                        // line a0: register offset
  logic start;                                          // new transfer in idle

  assign strobes  = bus_req.adr_strobe && bus_req.dat_strobe;
  assign hit      = addr_hit(bus_req.addr[tsr_pkg::TSR_ADDR_W-1:1],
                             address_match_jumpers, bus_req.mem_space);
  // removed jumper (high) enables the space
  assign space_en = bus_req.mem_space ? memory_space_enable_jumper
                                      : io_space_enable_jumper;
  assign reg_sel  = bus_req.addr[0];
  assign start    = (s_q.fsm == TSR_IDLE) && strobes && hit;

  // ****************************************************************
  // register file hooks
  // ****************************************************************
  logic       ctrl_we;                                  // write to control
  logic       sense_cap;                                // capture sense inputs
  logic [7:0] sense_in;                                 // assembled sense byte
  logic [7:0] ctrl_val;                                 // stored control
  logic [7:0] rdata;                                    // registered read data

  // write to offset one has no effect
  assign ctrl_we   = start && space_en && !bus_req.rd
                     && (reg_sel == tsr_pkg::TSR_OFF_CTRL) && !clr;
  assign sense_cap = start && space_en && bus_req.rd
                     && (reg_sel == tsr_pkg::TSR_OFF_SENSE);

  // pack sensor pairs
  always_comb begin
    sense_in = 8'h00;
    for (int n = 0; n < SEGMENTS; n++) begin
      sense_in[2*n+tsr_pkg::TSR_CUR_POS]  = seg_current_flow[n];
      sense_in[2*n+tsr_pkg::TSR_VOLT_POS] = seg_voltage_ok[n];
    end
  end

  tsr_regs u_regs (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clr        (clr),
    .ctrl_we    (ctrl_we),
    .ctrl_wdata (bus_req.wdata),
    .sense_cap  (sense_cap),
    .sense_in   (sense_in),
    .rd_sel     (reg_sel),
    .ctrl_out   (ctrl_val),
    .rdata      (rdata)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d      = s_q;
    s_d.act  = sense_cap;
    s_d.fail = clr;
    // segment power and polarity outputs from the control pairs
    for (int n = 0; n < SEGMENTS; n++) begin
      s_d.pwr[n] = clr ? 1'b0 : pair_bit(ctrl_val, n, tsr_pkg::TSR_PWR_POS);
      s_d.pol[n] = pair_bit(ctrl_val, n, tsr_pkg::TSR_DIR_POS);
      // short or fault when voltage bit low
      s_d.bad[n] = (tsr_pkg::tsr_seg_state_t'({seg_voltage_ok[n], seg_current_flow[n]})
                    inside {tsr_pkg::TSR_SEG_SHORT, tsr_pkg::TSR_SEG_FAULT});
    end
    case (s_q.fsm)
      // accept a matched transfer
      TSR_IDLE: begin
        // both space enables fitted: give no answer at all
        if (start && !(memory_space_enable_jumper || io_space_enable_jumper)) begin
          s_d.fsm = TSR_QUIET;
        end else if (start && !space_en) begin
          s_d.err = 1'b1;
          s_d.fsm = TSR_HOLD;
        end else if (start && bus_req.rd) begin
          s_d.fsm = TSR_RDLY;
        end else if (start) begin
          s_d.ack = 1'b1;
          s_d.fsm = TSR_HOLD;
        end
      end
      // one cycle delay, data register now valid
      TSR_RDLY: begin
        s_d.ack  = 1'b1;
        s_d.oe_n = 1'b0;
        s_d.fsm  = TSR_HOLD;
      end
      // hold the answer until strobes drop
      TSR_HOLD: begin
        if (!strobes) begin
          s_d.ack  = 1'b0;
          s_d.err  = 1'b0;
          s_d.oe_n = 1'b1;
          s_d.fsm  = TSR_IDLE;
        end
      end
      // ignored transfer, silent until strobes drop
      TSR_QUIET: begin
        if (!strobes) begin
          s_d.fsm = TSR_IDLE;
        end
      end
      default: begin
        s_d.fsm = TSR_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q      <= '0;
      s_q.fsm  <= TSR_IDLE;
      s_q.oe_n <= 1'b1;
      s_q.fail <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign bus_rsp.transfer_acknowledge = s_q.ack;
  assign bus_rsp.transfer_error       = s_q.err;
  assign bus_rsp.rdata_oe_n           = s_q.oe_n;
  assign bus_rsp.rdata                = rdata;
  assign seg_power_on                 = s_q.pwr;
  assign seg_polarity                 = s_q.pol;
  assign seg_state_bad                = s_q.bad;
  assign fail_ind                     = s_q.fail;
  assign activity_ind                 = s_q.act;

endmodule : tsr_top

// ===== sim/tsr_bus_master.sv
`timescale 1ns/1ps
// ****************************************************************
// bus master model: one transfer at a time, driven on falling edges
// ****************************************************************
module tsr_bus_master (
  input  wire logic                  sys_clk,
  input  wire tsr_pkg::tsr_bus_rsp_t bus_rsp,
  output tsr_pkg::tsr_bus_req_t      bus_req
);
  // idle bus at time zero
  initial bus_req = '0;
  // res: 0 acknowledged, 1 transfer error, 2 no answer
  task automatic xfer(input logic m, input logic r, input logic [19:0] a,
                      input logic [7:0] wd, output logic [7:0] rd_d,
                      output logic [1:0] res);
    int n;
    res  = 2'h2;
    rd_d = 8'hXX;
    @(negedge sys_clk);
    bus_req <= '{a, 1'b1, 1'b1, m, r, wd};  // request held until answered or 8 cycles pass
    for (n = 0; n < 8; n++) begin
      @(negedge sys_clk);
      if (bus_rsp.transfer_acknowledge === 1'b1 || bus_rsp.transfer_error === 1'b1) begin
        res  = (bus_rsp.transfer_error === 1'b1) ? 2'h1 : 2'h0;
        rd_d = (bus_rsp.rdata_oe_n === 1'b0) ? bus_rsp.rdata : 8'hXX;
        break;
      end
    end
    // hold the request through the rising edge that samples the answer high
    @(negedge sys_clk);
    // strobes removed, released lines show the inverse of their last value
    bus_req <= '{~a, 1'b0, 1'b0, ~m, ~r, ~wd};
    repeat (2) @(negedge sys_clk);
  endtask : xfer
endmodule : tsr_bus_master

// ===== sim/tsr_top_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker for the track segment register slave
// ****************************************************************
module tsr_top_checker #(
  parameter int SEGMENTS = tsr_pkg::TSR_SEGMENTS
) (
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  input wire logic                  sys_reset_n,
  input wire tsr_pkg::tsr_bus_req_t bus_req,
  input wire tsr_pkg::tsr_bus_rsp_t bus_rsp,
  input wire logic [SEGMENTS-1:0]   seg_voltage_ok,
  input wire logic [SEGMENTS-1:0]   seg_power_on,
  input wire logic [SEGMENTS-1:0]   seg_state_bad,
  input wire logic                  fail_ind,
  input wire logic                  activity_ind
);
  logic ack;  // acknowledge shorthand
  logic err;  // error shorthand
  logic stb;  // both strobes up
  assign ack = bus_rsp.transfer_acknowledge;
  assign err = bus_rsp.transfer_error;
  assign stb = bus_req.adr_strobe && bus_req.dat_strobe;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_WR_ACK: assert property ($rose(ack) && !bus_req.rd |-> $past(stb) && !$past(ack))
    else $error("write acknowledge not one cycle after strobes");
  AST_RD_ACK: assert property ($rose(ack) && bus_req.rd |-> $past(stb, 2) && !bus_rsp.rdata_oe_n)
    else $error("read acknowledge timing or data enable wrong");
  AST_ACT_ACK: assert property (activity_ind |=> ack && !bus_rsp.rdata_oe_n && bus_req.rd)
    else $error("activity pulse without read answer");
  AST_ACT_PULSE: assert property (activity_ind |=> !activity_ind)
    else $error("activity pulse longer than one cycle");
  AST_EXCL: assert property (!(ack && err))
    else $error("acknowledge and error together");
  AST_RELEASE: assert property ((!bus_req.adr_strobe && !bus_req.dat_strobe) [*2]
    |-> !ack && !err && bus_rsp.rdata_oe_n)
    else $error("answer not released after strobes dropped");
  AST_FAIL: assert property (!sys_reset_n |=> fail_ind)
    else $error("fail indicator dark during system reset");
  AST_CLEAR: assert property (!sys_reset_n [*3] |-> seg_power_on == '0)
    else $error("segment power on during system reset");
  AST_BAD: assert property ((seg_voltage_ok == $past(seg_voltage_ok)) [*3]
    |-> seg_state_bad == ~seg_voltage_ok)
    else $error("bad segment flag does not follow voltage sense");
endmodule : tsr_top_checker

bind tsr_top tsr_top_checker #(.SEGMENTS(SEGMENTS)) u_tsr_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .sys_reset_n(sys_reset_n),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .seg_voltage_ok(seg_voltage_ok),
  .seg_power_on(seg_power_on), .seg_state_bad(seg_state_bad),
  .fail_ind(fail_ind), .activity_ind(activity_ind)
);

// ===== sim/tsr_top_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tsr_top_bench;
  // one table row: request, sense inputs, expected result
  typedef struct packed {
    logic m; logic r; logic [19:0] a; logic [7:0] wd;
    logic [3:0] v; logic [3:0] c; logic [1:0] res;
  } tsr_row_t;
  logic                  sys_clk, sys_rst, sys_reset_n, supply_good;
  logic [19:1]           jmp;             // board address jumpers
  logic                  mem_en, io_en;   // space enable jumpers
  logic [3:0]            seg_voltage_ok, seg_current_flow;
  tsr_pkg::tsr_bus_req_t bus_req;
  tsr_pkg::tsr_bus_rsp_t bus_rsp;
  logic [3:0]            seg_power_on, seg_polarity, seg_state_bad;
  logic                  fail_ind, activity_ind;
  logic [7:0]            rd_d, exp_ctrl;  // read data, expected control value
  logic [1:0]            res;
  int                    failures, samples_checked, cycles, act_cnt, act0;
  tsr_row_t              rows [12];
  tsr_bus_master u_mst (.sys_clk(sys_clk), .bus_rsp(bus_rsp), .bus_req(bus_req));
  tsr_top #(.SEGMENTS(4)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sys_reset_n(sys_reset_n),
    .supply_good(supply_good), .address_match_jumpers(jmp),
    .memory_space_enable_jumper(mem_en), .io_space_enable_jumper(io_en),
    .bus_req(bus_req), .seg_voltage_ok(seg_voltage_ok),
    .seg_current_flow(seg_current_flow), .bus_rsp(bus_rsp),
    .seg_power_on(seg_power_on), .seg_polarity(seg_polarity),
    .seg_state_bad(seg_state_bad), .fail_ind(fail_ind), .activity_ind(activity_ind)
  );
  // interleave two nibbles: lo on even bits, hi on odd bits
  function automatic logic [7:0] weave(input logic [3:0] hi, input logic [3:0] lo);
    for (int n = 0; n < 4; n++) begin
      weave[2*n]   = lo[n];
      weave[2*n+1] = hi[n];
    end
  endfunction : weave
  // pick the odd (power) or even (direction) bits of a control byte
  function automatic logic [3:0] pick(input logic [7:0] x, input int odd);
    for (int n = 0; n < 4; n++) pick[n] = x[2*n+odd];
  endfunction : pick
  // print counts and verdict, then stop
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // read the control register and compare with the expected value
  task automatic rd_ctrl;
    u_mst.xfer(1'b0, 1'b1, 20'h003F0, 8'h00, rd_d, res);
    `CHK(rd_d, exp_ctrl)
  endtask : rd_ctrl
  always #25 sys_clk = ~sys_clk;
  // activity pulse counter and hang guard
  always @(posedge sys_clk) begin
    if (activity_ind === 1'b1) act_cnt++;
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    sys_clk = 0; sys_rst = 1; sys_reset_n = 1; supply_good = 1;
    jmp = 19'h0A1F8; mem_en = 1; io_en = 1;  // io 0x3F0, memory 0x143F0
    seg_voltage_ok = 4'hF; seg_current_flow = 4'h0; exp_ctrl = 8'h00;
    rows = '{
      '{0, 1, 20'h003F0, 8'h00, 4'hF, 4'h0, 2'h0}, '{0, 0, 20'h003F0, 8'hA5, 4'hF, 4'h0, 2'h0},
      '{0, 1, 20'h003F0, 8'h00, 4'hF, 4'h0, 2'h0}, '{1, 0, 20'h143F0, 8'h5A, 4'hF, 4'h0, 2'h0},
      '{1, 1, 20'h143F0, 8'h00, 4'hF, 4'h0, 2'h0}, '{0, 1, 20'h0A3F0, 8'h00, 4'hF, 4'h0, 2'h0},
      '{1, 1, 20'h003F0, 8'h00, 4'hF, 4'h0, 2'h2}, '{0, 0, 20'h003F2, 8'hFF, 4'hF, 4'h0, 2'h2},
      '{0, 1, 20'h003F1, 8'h00, 4'hB, 4'h6, 2'h0}, '{0, 0, 20'h003F1, 8'hFF, 4'hB, 4'h6, 2'h0},
      '{1, 1, 20'h143F1, 8'h00, 4'h0, 4'hF, 2'h0}, '{0, 1, 20'h003F0, 8'h00, 4'h0, 4'hF, 2'h0}};
    repeat (12) @(negedge sys_clk);
    sys_rst = 0;
    repeat (4) @(negedge sys_clk);
    // table of ordinary transfers
    foreach (rows[i]) begin
      seg_voltage_ok = rows[i].v;
      seg_current_flow = rows[i].c;
      u_mst.xfer(rows[i].m, rows[i].r, rows[i].a, rows[i].wd, rd_d, res);
      `CHK(res, rows[i].res)
      if (res === 2'h0 && !rows[i].r && !rows[i].a[0]) exp_ctrl = rows[i].wd;
      if (res === 2'h0 && rows[i].r)
        `CHK(rd_d, rows[i].a[0] ? weave(rows[i].v, rows[i].c) : exp_ctrl)
      `CHK(seg_power_on, pick(exp_ctrl, 1))
      `CHK(seg_polarity, pick(exp_ctrl, 0))
      `CHK(seg_state_bad, ~rows[i].v)
      `CHK(bus_rsp.transfer_acknowledge, 1'b0)
    end
    // disabled memory space gives an error, io space still answers
    mem_en = 0;
    u_mst.xfer(1'b1, 1'b1, 20'h143F0, 8'h00, rd_d, res);
    `CHK(res, 2'h1)
    rd_ctrl();
    // both spaces disabled: no answer at all and nothing stored
    io_en = 0;
    u_mst.xfer(1'b0, 1'b0, 20'h003F0, 8'h0F, rd_d, res);
    `CHK(res, 2'h2)
    mem_en = 1;
    io_en = 1;
    rd_ctrl();
    // back-to-back sense reads give one activity pulse each
    act0 = act_cnt;
    repeat (2) u_mst.xfer(1'b0, 1'b1, 20'h003F1, 8'h00, rd_d, res);
    `CHK(act_cnt - act0, 2)
    // system reset lights fail and clears control
    sys_reset_n = 0;
    repeat (4) @(negedge sys_clk);
    `CHK(fail_ind, 1'b1)
    `CHK(seg_power_on, 4'h0)
    sys_reset_n = 1;
    repeat (2) @(negedge sys_clk);
    `CHK(fail_ind, 1'b0)
    exp_ctrl = 8'h00;
    rd_ctrl();
    // master duty: power segment zero, let it settle, poll, cut it on a short
    exp_ctrl = 8'h02;
    u_mst.xfer(1'b0, 1'b0, 20'h003F0, exp_ctrl, rd_d, res);
    `CHK(seg_power_on, 4'h1)
    repeat (400) @(negedge sys_clk);
    seg_voltage_ok = 4'hE;
    seg_current_flow = 4'h1;
    u_mst.xfer(1'b0, 1'b1, 20'h003F1, 8'h00, rd_d, res);
    `CHK(rd_d, 8'hA9)
    if (!rd_d[1]) exp_ctrl = 8'h00;
    u_mst.xfer(1'b0, 1'b0, 20'h003F0, exp_ctrl, rd_d, res);
    `CHK(seg_power_on, 4'h0)
    `CHK(seg_state_bad, 4'h1)
    // speed set by toggling the power bit
    seg_voltage_ok = 4'hF;
    for (int k = 0; k < 6; k++) begin
      exp_ctrl = (k % 2 == 0) ? 8'h02 : 8'h00;
      u_mst.xfer(1'b0, 1'b0, 20'h003F0, exp_ctrl, rd_d, res);
      `CHK(seg_power_on, {3'h0, exp_ctrl[1]})
    end
    // supply loss with all segments powered
    u_mst.xfer(1'b0, 1'b0, 20'h003F0, 8'hFF, rd_d, res);
    `CHK(seg_power_on, 4'hF)
    supply_good = 0;
    @(negedge sys_clk);
    `CHK(fail_ind, 1'b0)
    repeat (5) @(negedge sys_clk);
    `CHK(fail_ind, 1'b1)
    `CHK(seg_power_on, 4'h0)
    supply_good = 1;
    repeat (5) @(negedge sys_clk);
    `CHK(fail_ind, 1'b0)
    rd_ctrl();
    close_out();
  end
endmodule : tsr_top_bench
